// [src/sdcs_consts.svh]
`ifndef SDCS_CONSTS_SVH
`define SDCS_CONSTS_SVH

// System clock and converter master clock, in hertz.
`define SDCS_CLK_HZ 50_000_000
`define SDCS_MASTER_CLOCK_FREQUENCY_HZ 64_000
// System clocks per modulator sample; the fraction is dropped.
`define SDCS_MOD_DIV (`SDCS_CLK_HZ / `SDCS_MASTER_CLOCK_FREQUENCY_HZ)
// Filter -3 dB bandwidth as hundredths of the output data rate.
`define SDCS_BW_CENTI 24

// Register byte offsets.
`define SDCS_ADR_CTRL 8'h00
`define SDCS_ADR_STATUS 8'h04
`define SDCS_ADR_DATA 8'h08
`define SDCS_ADR_IRQ_STAT 8'h0C
`define SDCS_ADR_IRQ_MASK 8'h10
`define SDCS_ADR_BW 8'h14

// Control register fields.
`define SDCS_CTRL_CHAN_LSB 0
`define SDCS_CTRL_CHAN_MSB 2
`define SDCS_CTRL_CHOP_BIT 3
`define SDCS_CTRL_BIPOLAR_BIT 4
`define SDCS_CTRL_BUF_BIT 5
`define SDCS_CTRL_RATE_LSB 8
`define SDCS_CTRL_RATE_MSB 11
`define SDCS_CTRL_MASK 32'h0000_0F3F
`define SDCS_CTRL_RST 32'h0000_0A08
`define SDCS_RATE_MIN 4'h4

// Interrupt status bits.
`define SDCS_IRQ_CONVERSION_READY_FLAG_BIT 0
`define SDCS_IRQ_CAL_BIT 1
`define SDCS_IRQ_MASK_W 32'h0000_0003

// Result coding.
`define SDCS_MID_SCALE 24'h80_0000
`define SDCS_MOD_FS 27'h080_0000

`endif

// [src/sdcs_pkg.sv]
package sdcs_pkg;

    typedef enum logic [1:0] {
        SDCS_FLUSHED,
        SDCS_PRIMED,
        SDCS_RUNNING
    } sdcs_settle_e;

    typedef logic [23:0] sdcs_code_t;
    typedef logic signed [24:0] sdcs_sample_t;
    typedef logic signed [16:0] sdcs_sum_t;

endpackage : sdcs_pkg

// [src/sdcs_mod_if.sv]
`timescale 1ns/100ps
`default_nettype none

interface sdcs_mod_if;
    logic tick;
    logic mod_bit;
    logic flush;
    sdcs_pkg::sdcs_sample_t x;
    logic [3:0] rate_shift;
    sdcs_pkg::sdcs_sum_t sum;
    logic done;

    modport mod (input flush, input x, output tick, output mod_bit);
    modport dec (input tick, input mod_bit, input flush, input rate_shift,
                 output sum, output done);
    modport ctl (output flush, output x, output rate_shift, input sum, input done);
endinterface : sdcs_mod_if

`default_nettype wire

// [src/sdcs_modulator.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sdcs_consts.svh"

module sdcs_modulator (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Modulator side of the filter link
    sdcs_mod_if.mod mif
);
    import sdcs_pkg::*;

    localparam logic [9:0] DIV_LAST = 10'(`SDCS_MOD_DIV - 1);

    logic [9:0] div_reg;
    logic [9:0] div_next;
    logic signed [26:0] integ_reg;
    logic signed [26:0] integ_next;
    logic signed [26:0] fb;
    logic tick_reg;
    logic bit_reg;
    logic bit_next;
    wire sample_now = !mif.flush && (div_reg == DIV_LAST);

    ////////////////////////////////////////////////////////////////////////
    // One bit per master clock period; a flush clears the loop state.
    assign div_next = (mif.flush || div_reg == DIV_LAST) ? 10'h000 : div_reg + 10'h001;
    assign fb = (integ_reg >= 0) ? $signed(`SDCS_MOD_FS) : -$signed(`SDCS_MOD_FS);
    assign integ_next = mif.flush ? 27'h000_0000 :
                        sample_now ? integ_reg + 27'(mif.x) - fb : integ_reg;
    assign bit_next = sample_now ? (integ_reg >= 0) : bit_reg;

    always_ff @(posedge clock) begin
        if (srst) begin
            div_reg <= 10'h000;
            integ_reg <= 27'h000_0000;
            tick_reg <= 1'b0;
            bit_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            integ_reg <= integ_next;
            tick_reg <= sample_now;
            bit_reg <= bit_next;
        end
    end

    assign mif.tick = tick_reg;
    assign mif.mod_bit = bit_reg;
endmodule : sdcs_modulator

`default_nettype wire

// [src/sdcs_decimator.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sdcs_consts.svh"

module sdcs_decimator (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Filter side of the modulator link
    sdcs_mod_if.dec mif
);
    import sdcs_pkg::*;

    logic [15:0] cnt_reg;
    logic [15:0] len_m1;
    sdcs_sum_t acc_reg;
    sdcs_sum_t acc_step;
    sdcs_sum_t out_reg;
    logic done_reg;
    wire last = (cnt_reg == len_m1);

    ////////////////////////////////////////////////////////////////////////
    // Sums 2^rate_shift modulator bits into one period result.
    assign len_m1 = (16'h0001 << mif.rate_shift) - 16'h0001;
    assign acc_step = acc_reg + (mif.mod_bit ? 17'sd1 : -17'sd1);

    always_ff @(posedge clock) begin
        if (srst || mif.flush) begin
            cnt_reg <= 16'h0000;
            acc_reg <= 17'sd0;
            out_reg <= 17'sd0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= mif.tick && last;
            if (mif.tick) begin
                cnt_reg <= last ? 16'h0000 : cnt_reg + 16'h0001;
                acc_reg <= last ? 17'sd0 : acc_step;
                out_reg <= last ? acc_step : out_reg;
            end
        end
    end

    assign mif.sum = out_reg;
    assign mif.done = done_reg;
endmodule : sdcs_decimator

`default_nettype wire

// [src/sdcs_sequencer.sv]
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "sdcs_consts.svh"

// Notes on behaviour
// - Channel change resets decimation filter and modulator.
// - Channel change drives ready flag inactive high until a new valid result.
// - With chopping, first valid result comes two periods after channel change.
// - Input steps never reset the filter; periods keep completing.
// - Step at a period start is fully reflected two periods later.
// - Step mid-period needs up to three periods to be reflected.
// - Cycling channels with chopping gives half the continuous data rate.
// - Without chopping a valid result follows one period after channel change.
// - Programmed rate is the continuous single-channel result rate.
// - Modulator samples at the master clock rate, filter decimates them.
// - Filter -3 dB bandwidth is 0.24 times the output data rate.
// - Unipolar results are straight binary, bipolar offset binary.
// - Bipolar zero input gives mid-scale code 0x800000.
module sdcs_sequencer (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter input and channel select
    input wire sdcs_pkg::sdcs_code_t ain_code,
    output logic [2:0] channel_sel,
    // Status outputs
    output logic conversion_ready_flag_n,
    output logic irq
);
    import sdcs_pkg::*;

    function automatic logic sdcs_hit(input logic [7:0] adr, input logic [7:0] off);
        sdcs_hit = (adr[7:2] == off[7:2]);
    endfunction : sdcs_hit

    function automatic logic [31:0] sdcs_wmask(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        sdcs_wmask = (old_v & ~m) | (new_v & m);
    endfunction : sdcs_wmask

    sdcs_mod_if mif ();

    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] stat_reg;
    logic [31:0] stat_next;
    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic irq_reg;
    logic flush_reg;
    logic ready_n_reg;
    logic ready_n_next;
    logic chop_neg_reg;
    sdcs_settle_e settle_reg;
    sdcs_settle_e settle_next;
    sdcs_sum_t prev_reg;
    sdcs_code_t data_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode. Writes land at the ack edge; a read samples one edge
    // earlier, so its side effect is taken at that sampling edge too.
    wire bus_req = wb_cyc_i && wb_stb_i;
    wire wr_ack = bus_req && wb_we_i && ack_reg;
    wire rd_take = bus_req && !wb_we_i && !ack_reg;
    wire wr_ctrl = wr_ack && sdcs_hit(wb_adr_i, `SDCS_ADR_CTRL);
    wire wr_stat = wr_ack && sdcs_hit(wb_adr_i, `SDCS_ADR_IRQ_STAT);
    wire wr_mask = wr_ack && sdcs_hit(wb_adr_i, `SDCS_ADR_IRQ_MASK);
    wire rd_data = rd_take && sdcs_hit(wb_adr_i, `SDCS_ADR_DATA);

    wire [31:0] ctrl_wv = sdcs_wmask(ctrl_reg, wb_dat_i, wb_sel_i) & `SDCS_CTRL_MASK;
    wire [2:0] chan = ctrl_reg[`SDCS_CTRL_CHAN_MSB:`SDCS_CTRL_CHAN_LSB];
    wire [3:0] rate_raw = ctrl_reg[`SDCS_CTRL_RATE_MSB:`SDCS_CTRL_RATE_LSB];
    wire chop_en = ctrl_reg[`SDCS_CTRL_CHOP_BIT];
    wire bipolar = ctrl_reg[`SDCS_CTRL_BIPOLAR_BIT];
    wire [3:0] rate_eff = (rate_raw < `SDCS_RATE_MIN) ? `SDCS_RATE_MIN : rate_raw;

    wire chan_chg = wr_ctrl &&
        (ctrl_wv[`SDCS_CTRL_CHAN_MSB:`SDCS_CTRL_CHAN_LSB] != chan);
    // Rate or chop changes also restart, since a half-built period is useless.
    wire restart = chan_chg || (wr_ctrl &&
        (ctrl_wv[`SDCS_CTRL_RATE_MSB:`SDCS_CTRL_RATE_LSB] != rate_raw ||
         ctrl_wv[`SDCS_CTRL_CHOP_BIT] != chop_en));
    wire cal_due = wr_ctrl &&
        (ctrl_wv[`SDCS_CTRL_RATE_MSB:`SDCS_CTRL_RATE_LSB] != rate_raw ||
         ctrl_wv[`SDCS_CTRL_BIPOLAR_BIT] != bipolar ||
         ctrl_wv[`SDCS_CTRL_BUF_BIT] != ctrl_reg[`SDCS_CTRL_BUF_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // Modulator input. Unipolar input is unsigned; recentring it makes the
    // final mid-scale flip give straight binary.
    // input coding
    wire signed [23:0] x_centred = bipolar ? $signed(ain_code)
                                           : $signed(ain_code ^ `SDCS_MID_SCALE);
    wire sdcs_sample_t x_ext = 25'(x_centred);
    assign mif.x = chop_neg_reg ? -x_ext : x_ext;
    assign mif.flush = flush_reg;
    assign mif.rate_shift = rate_eff;

    sdcs_modulator u_mod (
        .clock(clock),
        .srst(srst),
        .mif(mif.mod)
    );

    sdcs_decimator u_dec (
        .clock(clock),
        .srst(srst),
        .mif(mif.dec)
    );

    ////////////////////////////////////////////////////////////////////////
    // Period results. With chopping two opposite-polarity periods are
    // averaged, which cancels offset but costs one period of settling.
    // no step reset
    wire conv_done = mif.done && !flush_reg;
    wire sdcs_sum_t corr = chop_neg_reg ? -mif.sum : mif.sum;
    wire signed [17:0] pair = 18'(corr) + 18'(prev_reg);
    wire signed [17:0] avg = chop_en ? (pair >>> 1) : 18'(corr);
    wire [4:0] shamt = 5'd23 - {1'b0, rate_eff};
    wire signed [41:0] scaled = 42'(avg) <<< shamt;
    wire pos_ovf = !scaled[41] && (|scaled[40:23]);
    wire neg_ovf = scaled[41] && !(&scaled[40:23]);
    wire [23:0] code_s = pos_ovf ? 24'h7F_FFFF : neg_ovf ? 24'h80_0000 : scaled[23:0];
    wire sdcs_code_t code_out = code_s ^ `SDCS_MID_SCALE;

    wire valid_now = conv_done && (!chop_en || settle_reg != SDCS_FLUSHED);

    always_comb begin
        settle_next = settle_reg;
        if (restart) begin
            settle_next = SDCS_FLUSHED;
        end else if (conv_done) begin
            case (settle_reg)
                SDCS_FLUSHED: settle_next = SDCS_PRIMED;
                SDCS_PRIMED: settle_next = SDCS_RUNNING;
                SDCS_RUNNING: settle_next = SDCS_RUNNING;
                default: settle_next = SDCS_FLUSHED;
            endcase
        end
    end

    assign ready_n_next = restart ? 1'b1 : valid_now ? 1'b0 : rd_data ? 1'b1 : ready_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over a write-one clear in the same cycle.
    wire [31:0] stat_set = {30'h0000_0000, cal_due, valid_now};
    wire [31:0] stat_clr = wr_stat ? (wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}) : 32'h0000_0000;
    assign stat_next = ((stat_reg & ~stat_clr) | stat_set) & `SDCS_IRQ_MASK_W;
    assign mask_next = wr_mask ? (sdcs_wmask(mask_reg, wb_dat_i, wb_sel_i) & `SDCS_IRQ_MASK_W)
                               : mask_reg;
    assign ctrl_next = wr_ctrl ? ctrl_wv : ctrl_reg;

    wire [31:0] bw_centihz = 32'(`SDCS_MASTER_CLOCK_FREQUENCY_HZ * `SDCS_BW_CENTI) >> rate_eff;

    always_comb begin
        dat_next = 32'h0000_0000;
        case ({wb_adr_i[7:2], 2'b00})
            `SDCS_ADR_CTRL: dat_next = ctrl_reg;
            `SDCS_ADR_STATUS: dat_next = {28'h000_0000, chop_neg_reg, settle_reg, ready_n_reg};
            `SDCS_ADR_DATA: dat_next = {8'h00, data_reg};
            `SDCS_ADR_IRQ_STAT: dat_next = stat_reg;
            `SDCS_ADR_IRQ_MASK: dat_next = mask_reg;
            `SDCS_ADR_BW: dat_next = bw_centihz;
            default: dat_next = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (srst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            ctrl_reg <= `SDCS_CTRL_RST;
            stat_reg <= 32'h0000_0000;
            mask_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req && !ack_reg;
            dat_reg <= rd_take ? dat_next : dat_reg;
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            flush_reg <= 1'b0;
            ready_n_reg <= 1'b1;
            settle_reg <= SDCS_FLUSHED;
            chop_neg_reg <= 1'b0;
            prev_reg <= 17'sd0;
            data_reg <= 24'h00_0000;
        end else begin
            flush_reg <= restart;
            ready_n_reg <= ready_n_next;
            settle_reg <= settle_next;
            chop_neg_reg <= restart ? 1'b0 : (conv_done && chop_en) ? !chop_neg_reg : chop_neg_reg;
            prev_reg <= restart ? 17'sd0 : conv_done ? corr : prev_reg;
            data_reg <= valid_now ? code_out : data_reg;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign channel_sel = chan;
    assign conversion_ready_flag_n = ready_n_reg;
    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    property p_chan_flush;
        @(posedge clock) disable iff (srst) chan_chg |=> flush_reg && ready_n_reg;
    endproperty
    a_chan_flush: assert property (p_chan_flush) else $error("no flush on channel change");

    property p_flag_high;
        @(posedge clock) disable iff (srst) flush_reg |-> ready_n_reg ##1 ready_n_reg;
    endproperty
    a_flag_high: assert property (p_flag_high) else $error("ready active after change");

    property p_chop_settle;
        @(posedge clock) disable iff (srst)
            $fell(ready_n_reg) && chop_en |-> settle_reg == SDCS_RUNNING;
    endproperty
    a_chop_settle: assert property (p_chop_settle) else $error("chop result too early");

    property p_nochop_settle;
        @(posedge clock) disable iff (srst)
            $fell(ready_n_reg) && !chop_en |-> settle_reg != SDCS_FLUSHED;
    endproperty
    a_nochop_settle: assert property (p_nochop_settle) else $error("result before a period");

    property p_no_step_reset;
        @(posedge clock) disable iff (srst) flush_reg |-> $past(wr_ctrl);
    endproperty
    a_no_step_reset: assert property (p_no_step_reset) else $error("flush without write");

    property p_read_clears;
        @(posedge clock) disable iff (srst) rd_data && !valid_now && !restart |=> ready_n_reg;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("flag not cleared on read");

    property p_mid_scale;
        @(posedge clock) disable iff (srst) valid_now && scaled == 42'sd0 |=> data_reg == 24'h80_0000;
    endproperty
    a_mid_scale: assert property (p_mid_scale) else $error("zero not mid-scale");

    property p_timer_restart;
        @(posedge clock) disable iff (srst) flush_reg |=> !mif.done [*2];
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("period not restarted");

    property p_cal_flag;
        @(posedge clock) disable iff (srst)
            wr_ctrl && ctrl_wv[`SDCS_CTRL_RATE_MSB:`SDCS_CTRL_RATE_LSB] != rate_raw
            |=> stat_reg[`SDCS_IRQ_CAL_BIT] ##1 (irq_reg == mask_reg[`SDCS_IRQ_CAL_BIT]
                                                 || irq_reg);
    endproperty
    a_cal_flag: assert property (p_cal_flag) else $error("calibration flag missing");

    property p_irq_level;
        @(posedge clock) disable iff (srst) |(stat_reg & mask_reg) |=> irq_reg;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule : sdcs_sequencer

`default_nettype wire

// [verification/sdcs_src_model.sv]
`timescale 1ns/100ps
`default_nettype none

module sdcs_src_model (
    // Clock
    input wire logic clock,
    // Level presented on each input channel
    input wire logic [7:0][23:0] chan_lvl,
    // Converter side
    input wire logic [2:0] channel_sel,
    output var sdcs_pkg::sdcs_code_t ain_code
);
    import sdcs_pkg::*;

    // The front end lags a new selection by one clock, so a sequencer
    // that reuses stale samples after a switch shows up in the results.
    always_ff @(posedge clock) begin
        ain_code <= chan_lvl[channel_sel];
    end
endmodule : sdcs_src_model

`default_nettype wire

// [verification/sdcs_sequencer_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sdcs_consts.svh"

module sdcs_sequencer_tb_top;
    import sdcs_pkg::*;

    // One conversion period at rate setting 4, in clocks.
    localparam int T = 16 * `SDCS_MOD_DIV;
    localparam int SLACK = 800;
    localparam int BW4 = (`SDCS_MASTER_CLOCK_FREQUENCY_HZ * `SDCS_BW_CENTI) >> 4;

    logic clock;
    logic srst;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    logic [2:0] chan;
    logic flag_n;
    logic irq;
    sdcs_code_t ain;
    logic [7:0][23:0] lvl;
    logic [31:0] q;
    int fail_count;
    int n_checks;
    int cyc_n = 0;
    int t0;
    int tf;

    sdcs_sequencer dut_u (
        .clock(clock),
        .srst(srst),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .ain_code(ain),
        .channel_sel(chan),
        .conversion_ready_flag_n(flag_n),
        .irq(irq)
    );

    sdcs_src_model src_u (
        .clock(clock),
        .chan_lvl(lvl),
        .channel_sel(chan),
        .ain_code(ain)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic bad(input string m);
        fail_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : bad

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            bad(m);
        end
    endtask : chk

    // Short periods leave a coarse result, so codes are matched within a band.
    task automatic chk_near(input logic [31:0] got, input logic [23:0] exp, input string m);
        logic [23:0] d;
        d = (got[23:0] > exp) ? got[23:0] - exp : exp - got[23:0];
        n_checks++;
        if (got[31:24] !== 8'h00 || (d <= 24'h20_0000) !== 1'b1) begin
            bad(m);
        end
    endtask : chk_near

    task automatic chk_span(input int got, input int lo, input int hi, input string m);
        n_checks++;
        if (got < lo || got > hi) begin
            bad(m);
        end
    endtask : chk_span

    // Only the run's own cycle ceiling ends a wait for the answer.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic wait_flag(input int from, input int lo, input int hi);
        int n;
        n = 0;
        @(posedge clock);
        while (flag_n !== 1'b0 && n < 40000) begin
            @(posedge clock);
            n++;
        end
        chk_span(cyc_n - from, lo, hi, "ready timing");
        tf = cyc_n;
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 100000) begin
            bad("run too long");
            end_of_test;
        end
    end

    initial begin
        srst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0000_0000;
        fail_count = 0;
        n_checks = 0;
        lvl = '0;
        lvl[1] = 24'h40_0000;
        lvl[3] = 24'h40_0000;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        chk(flag_n, 1'b1, "flag after reset"); // Flag idle.
        chk(irq, 1'b0, "irq after reset");
        rd(`SDCS_ADR_CTRL);
        chk(q, `SDCS_CTRL_RST, "ctrl reset value");
        rd(8'h18);
        chk(q, 32'h0000_0000, "unmapped read");
        wr(`SDCS_ADR_IRQ_MASK, 32'h0000_0001);
        wr(`SDCS_ADR_CTRL, 32'h0000_0409);
        t0 = cyc_n;
        rd(`SDCS_ADR_IRQ_STAT);
        chk(q, 32'h0000_0002, "calibration request"); // Calibration due.
        wr(`SDCS_ADR_IRQ_STAT, 32'h0000_0002); // Recalibrate.
        rd(`SDCS_ADR_BW);
        chk(q, 32'(BW4), "bandwidth"); // Bandwidth figure.
        chk(chan, 3'h1, "channel select"); // New channel.
        wait_flag(t0, 2 * T - SLACK, 2 * T + SLACK); // Two periods.
        repeat (2) @(posedge clock);
        chk(irq, 1'b1, "irq raised");
        rd(`SDCS_ADR_DATA);
        chk_near(q, 24'h40_0000, "unipolar code"); // Straight binary.
        @(posedge clock);
        chk(flag_n, 1'b1, "flag after read"); // Read clears.
        wr(`SDCS_ADR_IRQ_STAT, 32'h0000_0001);
        wr(`SDCS_ADR_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge clock);
        chk(irq, 1'b0, "irq cleared");
        while (cyc_n < tf + T / 2) @(posedge clock);
        lvl[1] <= 24'hC0_0000;
        for (int i = 1; i <= 3; i++) begin
            wait_flag(tf, T - 2, T + 2); // Steady periods.
            rd(`SDCS_ADR_DATA);
        end
        chk_near(q, 24'hC0_0000, "stepped input"); // Third period.
        chk(irq, 1'b0, "masked irq");
        rd(`SDCS_ADR_IRQ_STAT);
        chk(q, 32'h0000_0001, "result event"); // Results keep coming.
        wr(`SDCS_ADR_CTRL, 32'h0000_0413);
        t0 = cyc_n;
        wr(`SDCS_ADR_IRQ_STAT, 32'h0000_0003); // Recalibrate.
        wait_flag(t0, T - SLACK, T + SLACK); // One period.
        wr(`SDCS_ADR_CTRL, 32'h0000_0412);
        t0 = cyc_n;
        repeat (2) @(posedge clock);
        chk(flag_n, 1'b1, "flag after switch"); // Forced idle.
        wait_flag(t0, T - SLACK, T + SLACK); // One period.
        rd(`SDCS_ADR_DATA);
        chk_near(q, `SDCS_MID_SCALE, "bipolar zero"); // Mid-scale.
        end_of_test;
    end
endmodule : sdcs_sequencer_tb_top

`default_nettype wire
